// ---- src/reload_timer.sv ----
// Functional notes
// - PWM mode decrements once per clock
// - PWM underflow reloads count from reload
// - Every underflow sets pending flag bit 3
// - Toggle mode inverts pin output each underflow
// - Interrupt needs enable and global enable
// - Interrupt each time pending newly set
// - Toggle-mode interrupt coincides with pin edges
// - Event mode decrements on pin transitions
// - Edge select picks rising or falling
// - Detects transitions up to half clock
// - Event mode underflow reloads, sets pending
// - Zero on Nth event, underflow next
// - Registers are separate byte locations
// - Interrupt enable cleared after reset
module reload_timer (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // Data memory access
  input wire reload_timer_pkg::mem_req_t memReq,
  output logic [7:0] memRdData,
  // Core status
  input wire logic globalIrqEn,
  // Timer pin
  input wire logic timerPinIn,
  input wire logic pinPreset,
  output logic timerPinOut,
  // Interrupt to core
  output logic timerIrq
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  reload_timer_pkg::ctrl_t ctrl_r;
  reload_timer_pkg::ctrl_t ctrl_nxt;
  logic [15:0] count_r;
  logic [15:0] reload_r;
  logic pinPrev_r;
  logic pinOut_r;
  logic irq_r;
  logic [7:0] rdData_r;

  logic pwmMode;
  logic eventMode;
  logic edgeSeen;
  logic tick;
  logic underflow;
  logic ctrlWr;
  logic countWr;

  // ----------------------------------------------------------------
  // Count enable
  // ----------------------------------------------------------------
  assign pwmMode = (ctrl_r.mode == reload_timer_pkg::MODE_PWM) ||
                   (ctrl_r.mode == reload_timer_pkg::MODE_PWM_TOGGLE);
  assign eventMode = (ctrl_r.mode == reload_timer_pkg::MODE_EVENT);
  // Falling edge when select set, rising otherwise
  assign edgeSeen = ctrl_r.edgeSel ? (pinPrev_r & ~timerPinIn) :
                    (~pinPrev_r & timerPinIn);
  assign tick = ctrl_r.run &
                (pwmMode | (eventMode & edgeSeen));
  assign underflow = tick & (count_r == 16'h0000);
  assign ctrlWr = memReq.wr && (memReq.addr == reload_timer_pkg::CTRL_ADDR);
  assign countWr = memReq.wr &&
                   ((memReq.addr == reload_timer_pkg::COUNT_LO_ADDR) ||
                    (memReq.addr == reload_timer_pkg::COUNT_HI_ADDR));

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      pinPrev_r <= 1'b1;
    end else begin
      pinPrev_r <= timerPinIn;
    end
  end

  // ----------------------------------------------------------------
  // Count register
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      count_r <= reload_timer_pkg::COUNT_RESET;
    end else if (memReq.wr &&
                 memReq.addr == reload_timer_pkg::COUNT_LO_ADDR) begin
      count_r[7:0] <= memReq.wdata;
    end else if (memReq.wr &&
                 memReq.addr == reload_timer_pkg::COUNT_HI_ADDR) begin
      count_r[15:8] <= memReq.wdata;
    end else if (underflow) begin
      count_r <= reload_r;
    end else if (tick) begin
      count_r <= count_r - 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // Reload register
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      reload_r <= reload_timer_pkg::RELOAD_RESET;
    end else if (memReq.wr &&
                 memReq.addr == reload_timer_pkg::RELOAD_LO_ADDR) begin
      reload_r[7:0] <= memReq.wdata;
    end else if (memReq.wr &&
                 memReq.addr == reload_timer_pkg::RELOAD_HI_ADDR) begin
      reload_r[15:8] <= memReq.wdata;
    end
  end

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------
  always_comb begin
    ctrl_nxt = ctrl_r;
    if (ctrlWr) begin
      ctrl_nxt = reload_timer_pkg::ctrl_t'(memReq.wdata);
      ctrl_nxt.rsvd = 2'b00;
    end
    // Hardware set beats a written zero
    ctrl_nxt.pending = ctrl_nxt.pending | underflow;
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_r <= reload_timer_pkg::ctrl_t'(reload_timer_pkg::CTRL_RESET);
    end else begin
      ctrl_r <= ctrl_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Pin output and interrupt
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      pinOut_r <= 1'b0;
    end else if (!ctrl_r.run) begin
      pinOut_r <= pinPreset;
    end else if (underflow &&
                 ctrl_r.mode == reload_timer_pkg::MODE_PWM_TOGGLE) begin
      pinOut_r <= ~pinOut_r;
    end
  end

  // Taken from next values so it lands with the pin edge
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= ctrl_nxt.pending & ctrl_nxt.irqEn & globalIrqEn;
    end
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rdData_r <= reload_timer_pkg::UNMAPPED_READ;
    end else if (memReq.rd) begin
      unique case (memReq.addr)
        reload_timer_pkg::RELOAD_LO_ADDR: rdData_r <= reload_r[7:0];
        reload_timer_pkg::RELOAD_HI_ADDR: rdData_r <= reload_r[15:8];
        reload_timer_pkg::COUNT_LO_ADDR: rdData_r <= count_r[7:0];
        reload_timer_pkg::COUNT_HI_ADDR: rdData_r <= count_r[15:8];
        reload_timer_pkg::CTRL_ADDR: rdData_r <= ctrl_r;
        default: rdData_r <= reload_timer_pkg::UNMAPPED_READ;
      endcase
    end
  end

  assign memRdData = rdData_r;
  assign timerPinOut = pinOut_r;
  assign timerIrq = irq_r;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence s_quiet;
    !countWr && !ctrlWr;
  endsequence

  sequence s_underflow;
    underflow && !countWr;
  endsequence

  property p_pwm_dec;
    @(posedge sys_clk) disable iff (!nrst)
    (pwmMode && ctrl_r.run && count_r != 16'h0000 && !countWr)
      |=> (count_r == $past(count_r) - 16'h0001);
  endproperty
  a_pwm_dec: assert property (p_pwm_dec)
    else $error("count did not decrement in PWM mode");

  property p_reload;
    @(posedge sys_clk) disable iff (!nrst)
    s_underflow |=> (count_r == $past(reload_r));
  endproperty
  a_reload: assert property (p_reload)
    else $error("count not reloaded on underflow");

  property p_pend_set;
    @(posedge sys_clk) disable iff (!nrst)
    underflow |=> ctrl_r.pending;
  endproperty
  a_pend_set: assert property (p_pend_set)
    else $error("pending flag not set on underflow");

  property p_toggle;
    @(posedge sys_clk) disable iff (!nrst)
    (underflow && ctrl_r.mode == reload_timer_pkg::MODE_PWM_TOGGLE)
      |=> (timerPinOut != $past(timerPinOut));
  endproperty
  a_toggle: assert property (p_toggle)
    else $error("pin output did not toggle on underflow");

  property p_irq_gate;
    @(posedge sys_clk) disable iff (!nrst)
    timerIrq |-> (ctrl_r.irqEn && ctrl_r.pending && $past(globalIrqEn));
  endproperty
  a_irq_gate: assert property (p_irq_gate)
    else $error("interrupt raised without both enables");

  property p_irq_new;
    @(posedge sys_clk) disable iff (!nrst)
    (underflow && !ctrl_r.pending && ctrl_r.irqEn && globalIrqEn
     && !ctrlWr) |=> timerIrq;
  endproperty
  a_irq_new: assert property (p_irq_new)
    else $error("no interrupt on newly set pending flag");

  property p_irq_edge;
    @(posedge sys_clk) disable iff (!nrst)
    (underflow && ctrl_r.mode == reload_timer_pkg::MODE_PWM_TOGGLE
     && ctrl_r.irqEn && globalIrqEn && !ctrlWr)
      |=> (timerIrq && $changed(timerPinOut));
  endproperty
  a_irq_edge: assert property (p_irq_edge)
    else $error("interrupt not aligned with pin transition");

  property p_event_count;
    @(posedge sys_clk) disable iff (!nrst)
    s_quiet ##0 (eventMode && ctrl_r.run && !edgeSeen)
      |=> $stable(count_r);
  endproperty
  a_event_count: assert property (p_event_count)
    else $error("event counter moved without an edge");

  property p_edge_dec;
    @(posedge sys_clk) disable iff (!nrst)
    (eventMode && ctrl_r.run && !ctrl_r.edgeSel && !pinPrev_r
     && timerPinIn && count_r != 16'h0000 && !countWr)
      |=> (count_r == $past(count_r) - 16'h0001);
  endproperty
  a_edge_dec: assert property (p_edge_dec)
    else $error("rising edge not counted");

  property p_stopped;
    @(posedge sys_clk) disable iff (!nrst)
    s_quiet ##0 !ctrl_r.run |=> ($stable(count_r) &&
      !$rose(ctrl_r.pending));
  endproperty
  a_stopped: assert property (p_stopped)
    else $error("stopped timer changed count");

  property p_set_wins;
    @(posedge sys_clk) disable iff (!nrst)
    (ctrlWr && !memReq.wdata[reload_timer_pkg::PEND_BIT] && underflow)
      |=> ctrl_r.pending;
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("written zero beat hardware pending set");

  property p_byte_wr;
    @(posedge sys_clk) disable iff (!nrst)
    (memReq.wr && memReq.addr == reload_timer_pkg::COUNT_LO_ADDR)
      |=> (count_r[7:0] == $past(memReq.wdata));
  endproperty
  a_byte_wr: assert property (p_byte_wr)
    else $error("count low byte write lost");

endmodule : reload_timer

// ---- shared/reload_timer_pkg.sv ----
package reload_timer_pkg;

  // ----------------------------------------------------------------
  // Register byte addresses in data memory
  // ----------------------------------------------------------------
  localparam logic [7:0] RELOAD_LO_ADDR = 8'hAA;
  localparam logic [7:0] RELOAD_HI_ADDR = 8'hAB;
  localparam logic [7:0] COUNT_LO_ADDR = 8'hAC;
  localparam logic [7:0] COUNT_HI_ADDR = 8'hAD;
  localparam logic [7:0] CTRL_ADDR = 8'hAE;

  // ----------------------------------------------------------------
  // Control register field positions
  // ----------------------------------------------------------------
  localparam int MODE_LSB = 6;
  localparam int EDGE_BIT = 5;
  localparam int RUN_BIT = 4;
  localparam int PEND_BIT = 3;
  localparam int IEN_BIT = 2;

  // ----------------------------------------------------------------
  // Values after reset
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [15:0] RELOAD_RESET = 16'h0000;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_EVENT = 2'b00,
    MODE_CAPTURE = 2'b01,
    MODE_PWM_TOGGLE = 2'b10,
    MODE_PWM = 2'b11
  } timer_mode_t;

  typedef struct packed {
    timer_mode_t mode;
    logic edgeSel;
    logic run;
    logic pending;
    logic irqEn;
    logic [1:0] rsvd;
  } ctrl_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } mem_req_t;

endpackage : reload_timer_pkg

// ---- testbench/pin_pulse_source.sv ----
module pin_pulse_source (
  // Clock
  input wire logic sys_clk,
  // Request from bench
  input wire logic go,
  input wire logic [7:0] nEdges,
  input wire logic [3:0] hold,
  // Timer pin side
  output logic pinLevel,
  output logic busy
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle high like the pull-up
  initial pinLevel = 1'b1;
  initial busy = 1'b0;
  // Each level held at least hold cycles
  always begin
    @(negedge sys_clk);
    if (go) begin
      busy = 1'b1;
      repeat (nEdges) begin
        pinLevel = ~pinLevel;
        repeat (hold) @(negedge sys_clk);
      end
      busy = 1'b0;
    end
  end
endmodule : pin_pulse_source

// ---- testbench/test_reload_timer_pwm_event_counter.sv ----
`define CHK(nm, e, g) begin nTests++; if ((g) !== (e)) begin errorCnt++; \
  $display("BAD %s exp %h got %h", nm, e, g); end end
module test_reload_timer_pwm_event_counter;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  reload_timer_pkg::mem_req_t memReq = '0;
  logic [7:0] memRdData;
  logic globalIrqEn = 1'b1;
  logic timerPinIn;
  logic pinPreset = 1'b1;
  logic timerPinOut;
  logic timerIrq;
  logic go = 1'b0;
  logic [7:0] nEdges = 8'h00;
  logic srcBusy;
  int errorCnt = 0;
  int nTests = 0;
  int a, b, p4, p9, n;
  logic [7:0] v;
  always #5 sys_clk = ~sys_clk;
  reload_timer u_dut (.sys_clk(sys_clk), .nrst(nrst), .memReq(memReq),
    .memRdData(memRdData), .globalIrqEn(globalIrqEn),
    .timerPinIn(timerPinIn), .pinPreset(pinPreset),
    .timerPinOut(timerPinOut), .timerIrq(timerIrq));
  pin_pulse_source u_src (.sys_clk(sys_clk), .go(go), .nEdges(nEdges),
    .hold(4'h1), .pinLevel(timerPinIn), .busy(srcBusy));
  task automatic closeOut();
    $display("tests %0d errors %0d", nTests, errorCnt);
    if (errorCnt == 0 && nTests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : closeOut
  task automatic wr(input logic [7:0] ad, input logic [7:0] d);
    @(negedge sys_clk);
    memReq = '{addr: ad, wdata: d, wr: 1'b1, rd: 1'b0};
    @(negedge sys_clk);
    memReq.wr = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] ad, output logic [7:0] d);
    @(negedge sys_clk);
    memReq = '{addr: ad, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(negedge sys_clk);
    memReq.rd = 1'b0;
    d = memRdData;
  endtask : rd
  task automatic rdChk(input logic [7:0] ad, input logic [7:0] e);
    logic [7:0] d;
    rd(ad, d);
    `CHK("register", e, d)
  endtask : rdChk
  task automatic waitToggle(output int cyc);
    logic p;
    p = timerPinOut;
    cyc = 0;
    do begin
      @(negedge sys_clk);
      cyc++;
    end while (timerPinOut === p && cyc < 400);
    `CHK("toggle", 1'b1, cyc < 400)
  endtask : waitToggle
  task automatic edges(input logic [7:0] k);
    @(negedge sys_clk);
    nEdges = k;
    go = 1'b1;
    wait (srcBusy);
    go = 1'b0;
    wait (!srcBusy);
    repeat (2) @(negedge sys_clk);
  endtask : edges
  initial begin
    repeat (20000) @(posedge sys_clk);
    errorCnt++;
    closeOut();
  end
  initial begin
    repeat (16) @(negedge sys_clk);
    nrst = 1'b1;
    `CHK("irq", 1'b0, timerIrq)
    for (int i = 0; i < 5; i++) rdChk(8'hAA + i[7:0], 8'h00);
    `CHK("pin", 1'b1, timerPinOut)
    wr(8'hAE, 8'h0C);
    rdChk(8'hAE, 8'h0C);
    `CHK("irq", 1'b1, timerIrq)
    wr(8'hAE, 8'h03);
    rdChk(8'hAE, 8'h00);
    `CHK("irq", 1'b0, timerIrq)
    wr(8'hAF, 8'hFF);
    rdChk(8'hAF, 8'h00);
    wr(8'hAC, 8'h00);
    wr(8'hAD, 8'h01);
    wr(8'hAA, 8'h04);
    wr(8'hAB, 8'h00);
    rdChk(8'hAD, 8'h01);
    rdChk(8'hAA, 8'h04);
    wr(8'hAE, 8'hB0);
    rd(8'hAC, v);
    a = v;
    rd(8'hAC, v);
    b = v;
    `CHK("decrement", 2, a - b)
    waitToggle(n);
    `CHK("pin", 1'b0, timerPinOut)
    waitToggle(p4);
    wr(8'hAA, 8'h09);
    waitToggle(n);
    waitToggle(p9);
    `CHK("period", 5, p9 - p4)
    rdChk(8'hAE, 8'hB8);
    `CHK("irq", 1'b0, timerIrq)
    wr(8'hAE, 8'hB4);
    waitToggle(n);
    `CHK("irq", 1'b1, timerIrq)
    wr(8'hAE, 8'hB4);
    @(negedge sys_clk);
    `CHK("irq", 1'b0, timerIrq)
    waitToggle(n);
    `CHK("irq", 1'b1, timerIrq)
    globalIrqEn = 1'b0;
    repeat (2) @(negedge sys_clk);
    `CHK("irq", 1'b0, timerIrq)
    wr(8'hAE, 8'h80);
    rd(8'hAC, v);
    repeat (5) @(negedge sys_clk);
    rdChk(8'hAC, v);
    `CHK("pin", 1'b1, timerPinOut)
    pinPreset = 1'b0;
    wr(8'hAA, 8'h00);
    wr(8'hAC, 8'h00);
    wr(8'hAE, 8'hD0);
    repeat (3) @(negedge sys_clk);
    `CHK("pin", 1'b0, timerPinOut)
    wr(8'hAE, 8'hD0);
    rdChk(8'hAE, 8'hD8);
    wr(8'hAE, 8'h80);
    globalIrqEn = 1'b1;
    wr(8'hAC, 8'h02);
    wr(8'hAD, 8'h00);
    wr(8'hAA, 8'h02);
    wr(8'hAE, 8'h34);
    edges(8'h04);
    rdChk(8'hAC, 8'h00);
    rdChk(8'hAE, 8'h34);
    edges(8'h01);
    rdChk(8'hAC, 8'h02);
    rdChk(8'hAE, 8'h3C);
    `CHK("irq", 1'b1, timerIrq)
    rd(8'hAE, v);
    n = v[3];
    rd(8'hAC, v);
    `CHK("events", 3, n * 3 + 2 - v)
    repeat (10) @(negedge sys_clk);
    rdChk(8'hAC, 8'h02);
    wr(8'hAE, 8'h14);
    edges(8'h01);
    rdChk(8'hAC, 8'h01);
    edges(8'h01);
    rdChk(8'hAC, 8'h01);
    `CHK("irq", 1'b0, timerIrq)
    closeOut();
  end
endmodule : test_reload_timer_pwm_event_counter
